// ==== logic/sar_seq_defs.svh ====
// Register offsets, field positions, reset values and timing figures
// for the converter sequencer. Included by the clock divider and sequencer files.
`ifndef SAR_SEQ_DEFS_SVH
`define SAR_SEQ_DEFS_SVH

`define ADDR_VREF 8'hea
`define ADDR_AIN 8'heb
`define ADDR_RES_MODE 8'hec
`define ADDR_TSAMP 8'hee
`define ADDR_CAP_LO 8'hef
`define ADDR_LEN 8'hf1
`define ADDR_CHAN 8'hf2
`define ADDR_FREEZE 8'hf3
`define ADDR_CLK_DIV 8'hf4
`define ADDR_VALID 8'hf6
`define ADDR_DAT_LO 8'hf7
`define ADDR_DAT_HI 8'hf8
`define ADDR_SCALE 8'hfa
`define ADDR_POWER 8'hfc

`define BIT_DIFF 6
`define BIT_CHAN_EN 2
`define BIT_CORE_WR_DIS 3
`define BIT_POWER_DOWN 5

`define RST_RES 2'h3
`define RST_CLK_DIV 3'h3
`define RST_POWER_DOWN 1'b1

`define SETTLE_STEP 6'h03
`define SETTLE_BASE 6'h03

`endif

// ==== logic/sar_seq_pkg.sv ====
// Types shared by the converter sequencer files.
package sar_seq_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SET, ST_CAPTURE} seq_state_t;
endpackage

// ==== logic/conv_clk_div.sv ====
// Converter clock divider: divides clk_in by div+1.
// Assumes clk_in is the 24 MHz reference; held low while powered down.
`timescale 1ns/100ps
`include "sar_seq_defs.svh"
module conv_clk_div (
	input wire logic clk_in, // Reference clock
	input wire logic reset_n_in, // Synchronous reset, active low
	input wire logic power_down_in, // Stops the divider
	input wire logic [2:0] div_in, // Divide factor minus one
	output logic conv_clk_out // Converter clock
);
	logic [2:0] cnt_ff;
	logic [2:0] div_ff;
	logic [2:0] half;
	logic wrap;

	// Divide factor is taken only at wrap so a period is never torn
	assign wrap = (cnt_ff == div_ff);
	assign half = 3'((4'(div_ff) + 4'h1) >> 1);

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in || power_down_in)
		begin
			cnt_ff <= 3'h0;
			div_ff <= `RST_CLK_DIV;
			conv_clk_out <= 1'b0;
		end
		else
		begin
			cnt_ff <= wrap ? 3'h0 : cnt_ff + 3'h1; // RQ2
			if (wrap)
				div_ff <= div_in;
			// Divide by one cannot be made from flops; output then stays high
			conv_clk_out <= wrap ? 1'b1 : ((cnt_ff + 3'h1) < half) || (div_ff == 3'h0);
		end
	end

	chk_div_period: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ2
		(!power_down_in && cnt_ff == 3'h0 && div_ff == 3'h5 && !$past(power_down_in))
		|-> ##5 (cnt_ff == 3'h5 || power_down_in))
		else $error("divider period wrong");
endmodule // conv_clk_div

// ==== logic/result_capture.sv ====
// Result latch: sign-extends the converter word to 16 bits and holds
// it while frozen. Assumes converter data is valid when latch_in pulses.
`timescale 1ns/100ps
module result_capture (
	input wire logic clk_in, // Reference clock
	input wire logic reset_n_in, // Synchronous reset, active low
	input wire logic latch_in, // End of capture pulse
	input wire logic freeze_in, // Hold stored result
	input wire logic [1:0] res_in, // Resolution code
	input wire logic [13:0] data_in, // Raw converter word
	output logic [15:0] result_out // Stored result
);
	// Bits above the selected width copy its top bit
	function automatic logic [15:0] sign_ext(input logic [13:0] d, input logic [1:0] r);
		case (r)
			2'h0: sign_ext = {{8{d[7]}}, d[7:0]};
			2'h1: sign_ext = {{6{d[9]}}, d[9:0]};
			2'h2: sign_ext = {{4{d[11]}}, d[11:0]};
			default: sign_ext = {{2{d[13]}}, d[13:0]};
		endcase
	endfunction

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			result_out <= 16'h0000;
		else if (latch_in && !freeze_in) // RQ16
			result_out <= sign_ext(data_in, res_in); // RQ10
	end

	chk_freeze_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ16
		$past(freeze_in) && $past(reset_n_in) |-> $stable(result_out))
		else $error("result changed while frozen");
	chk_sign_ext8: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ10
		(latch_in && !freeze_in && res_in == 2'h0)
		|=> result_out[15:8] == {8{result_out[7]}})
		else $error("8-bit result not sign extended");
endmodule // result_capture

// ==== logic/sar_adc_auto_sequencer.sv ====
// Automatic-mode sequencer for the successive-approximation converter:
// register file, Set/Capture state machine, converter control outputs.
// Assumes clk_in is the reference the state lengths count in, and that
// software programs the max state index and differential mode itself.
//
// How it works
// RQ1 - Converter stays powered down until bit cleared
// RQ2 - Converter clock is reference divided by div+1
// RQ3 - Software sets max state index to two
// RQ4 - Sequencer runs only while channel enabled
// RQ5 - Set lasts set-length reference cycles
// RQ6 - Set drives converter controls from settings
// RQ7 - Software selects differential mode
// RQ8 - Two-bit input scale forwarded during Set
// RQ9 - Two-bit resolution selects 8/10/12/14 bits
// RQ10 - Result is 16 bits, sign extended
// RQ11 - Sampling-time field sets settling cycles
// RQ12 - Run pulse at start of each Capture
// RQ13 - Capture lasts ten-bit length reference cycles
// RQ14 - Capture end latches result, pulses valid
// RQ15 - Result read as high and low byte
// RQ16 - Result held while freeze bit set
// RQ17 - Sample period is Set plus Capture
// RQ18 - Settling cycles are three per step plus three
// RQ19 - Resolution code decodes, resets to 14 bits
// RQ20 - Input selects route pins, sensor, ground, none
// RQ21 - Capture returns straight to Set while enabled
// RQ22 - Disable returns idle with no run or update
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "sar_seq_defs.svh"
module sar_adc_auto_sequencer (
	input wire logic clk_in, // Reference clock
	input wire logic reset_n_in, // Synchronous reset, active low
	input wire logic [7:0] reg_addr_in, // Register address
	input wire logic [7:0] reg_wdata_in, // Register write data
	input wire logic reg_wr_in, // Write strobe
	input wire logic reg_rd_in, // Read strobe
	output logic [7:0] reg_rdata_out, // Read data, cycle after strobe
	input wire logic [13:0] conv_data_in, // Raw converter word
	output logic converter_power_down_out, // Converter power down
	output logic conv_clk_out, // Converter clock
	output logic conv_run_out, // Start one conversion
	output logic conv_en_diff_out, // Differential mode
	output logic [3:0] conv_ain_p_out, // Positive input select
	output logic [3:0] conv_ain_n_out, // Negative input select
	output logic [1:0] conv_vref_out, // Reference select
	output logic [1:0] input_scale_select_out, // Input scaling
	output logic [1:0] conv_res_out, // Resolution code
	output logic [3:0] conv_tsamp_out, // Sampling-time code
	output logic [5:0] settle_cycles_out, // Settling converter clocks
	output logic result_valid_flag_out // Result valid pulse
);
	logic [1:0] vref_ff;
	logic [7:0] ain_ff;
	logic [1:0] res_ff;
	logic diff_ff;
	logic [3:0] tsamp_ff;
	logic [7:0] cap_lo_ff;
	logic [7:0] len_ff;
	logic [7:0] chan_ff;
	logic freeze_ff;
	logic [2:0] clk_div_ff;
	logic [1:0] scale_ff;
	logic power_down_ff;
	logic [7:0] rdata_ff;
	logic result_valid_flag_ff;
	logic run_ff;
	logic [9:0] seg_cnt_ff;
	sar_seq_pkg::seq_state_t state_ff;
	sar_seq_pkg::seq_state_t nxt_state;
	logic [15:0] result;
	logic [9:0] set_last;
	logic [9:0] cap_last;
	logic [9:0] capture_state_length;
	logic chan_en;
	logic seg_done;
	logic capture_end;
	logic [7:0] rd_mux;

	// Last count index of a state of the given length; zero is taken as one
	function automatic logic [9:0] last_index(input logic [9:0] len);
		last_index = (len == 10'h000) ? 10'h000 : len - 10'h001;
	endfunction

	// Settling converter clocks for a sampling-time code
	function automatic logic [5:0] settle_of(input logic [3:0] code);
		settle_of = 6'(code) * `SETTLE_STEP + `SETTLE_BASE;
	endfunction

	function automatic logic wr_hit(input logic [7:0] a);
		wr_hit = reg_wr_in && (reg_addr_in == a);
	endfunction

	assign capture_state_length = {len_ff[7:6], cap_lo_ff}; // RQ13
	assign set_last = last_index({6'h00, len_ff[3:0]}); // RQ5
	assign cap_last = last_index(capture_state_length); // RQ13
	assign chan_en = chan_ff[`BIT_CHAN_EN] && !power_down_ff; // RQ1 RQ4
	assign seg_done = (state_ff == sar_seq_pkg::ST_SET) ? (seg_cnt_ff == set_last)
		: (seg_cnt_ff == cap_last);
	assign capture_end = (state_ff == sar_seq_pkg::ST_CAPTURE) && seg_done && chan_en; // RQ14

	// Register write side
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			vref_ff <= 2'h0;
			ain_ff <= 8'h00;
			res_ff <= `RST_RES; // RQ19
			diff_ff <= 1'b0;
			tsamp_ff <= 4'h0;
			cap_lo_ff <= 8'h00;
			len_ff <= 8'h00;
			chan_ff <= 8'h00;
			freeze_ff <= 1'b0;
			clk_div_ff <= `RST_CLK_DIV;
			scale_ff <= 2'h0;
			power_down_ff <= `RST_POWER_DOWN; // RQ1
		end
		else
		begin
			if (wr_hit(`ADDR_VREF))
				vref_ff <= reg_wdata_in[1:0];
			if (wr_hit(`ADDR_AIN))
				ain_ff <= reg_wdata_in; // RQ20
			if (wr_hit(`ADDR_RES_MODE))
			begin
				res_ff <= reg_wdata_in[1:0]; // RQ9
				diff_ff <= reg_wdata_in[`BIT_DIFF];
			end
			if (wr_hit(`ADDR_TSAMP))
				tsamp_ff <= reg_wdata_in[3:0];
			if (wr_hit(`ADDR_CAP_LO))
				cap_lo_ff <= reg_wdata_in;
			if (wr_hit(`ADDR_LEN))
				len_ff <= reg_wdata_in;
			if (wr_hit(`ADDR_CHAN))
				chan_ff <= reg_wdata_in & 8'h3c;
			if (wr_hit(`ADDR_FREEZE))
				freeze_ff <= reg_wdata_in[0];
			if (wr_hit(`ADDR_CLK_DIV))
				clk_div_ff <= reg_wdata_in[2:0];
			if (wr_hit(`ADDR_SCALE))
				scale_ff <= reg_wdata_in[7:6]; // RQ8
			if (wr_hit(`ADDR_POWER))
				power_down_ff <= reg_wdata_in[`BIT_POWER_DOWN]; // RQ1
		end
	end

	// Read side; unmapped addresses read zero
	always_comb
	begin
		case (reg_addr_in)
			`ADDR_VREF: rd_mux = {6'h00, vref_ff};
			`ADDR_AIN: rd_mux = ain_ff;
			`ADDR_RES_MODE: rd_mux = {1'b0, diff_ff, 4'h0, res_ff};
			`ADDR_TSAMP: rd_mux = {4'h0, tsamp_ff};
			`ADDR_CAP_LO: rd_mux = cap_lo_ff;
			`ADDR_LEN: rd_mux = len_ff;
			`ADDR_CHAN: rd_mux = chan_ff;
			`ADDR_FREEZE: rd_mux = {7'h00, freeze_ff};
			`ADDR_CLK_DIV: rd_mux = {5'h00, clk_div_ff};
			`ADDR_VALID: rd_mux = {7'h00, result_valid_flag_ff};
			`ADDR_DAT_LO: rd_mux = result[7:0]; // RQ15
			`ADDR_DAT_HI: rd_mux = result[15:8]; // RQ15
			`ADDR_SCALE: rd_mux = {scale_ff, 6'h00};
			`ADDR_POWER: rd_mux = {2'h0, power_down_ff, 5'h00};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= reg_rd_in ? rd_mux : 8'h00;
	end

	// Sequencer: Set and Capture alternate back to back, so one sample
	// takes set length plus capture length reference cycles.
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			sar_seq_pkg::ST_IDLE:
				if (chan_en)
					nxt_state = sar_seq_pkg::ST_SET; // RQ4
			sar_seq_pkg::ST_SET:
				if (!chan_en)
					nxt_state = sar_seq_pkg::ST_IDLE; // RQ22
				else if (seg_done)
					nxt_state = sar_seq_pkg::ST_CAPTURE; // RQ5
			sar_seq_pkg::ST_CAPTURE:
				if (!chan_en)
					nxt_state = sar_seq_pkg::ST_IDLE; // RQ22
				else if (seg_done)
					nxt_state = sar_seq_pkg::ST_SET; // RQ17 RQ21
			default:
				nxt_state = sar_seq_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			state_ff <= sar_seq_pkg::ST_IDLE;
			seg_cnt_ff <= 10'h000;
			run_ff <= 1'b0;
			result_valid_flag_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			seg_cnt_ff <= (nxt_state != state_ff) ? 10'h000 : seg_cnt_ff + 10'h001;
			run_ff <= (nxt_state == sar_seq_pkg::ST_CAPTURE)
				&& (state_ff != sar_seq_pkg::ST_CAPTURE); // RQ12
			result_valid_flag_ff <= capture_end; // RQ14
		end
	end

	// Controls are applied during Set so a change mid-capture cannot
	// disturb the conversion already running.
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			conv_en_diff_out <= 1'b0;
			conv_ain_p_out <= 4'h0;
			conv_ain_n_out <= 4'h0;
			conv_vref_out <= 2'h0;
			input_scale_select_out <= 2'h0;
			conv_res_out <= `RST_RES;
			conv_tsamp_out <= 4'h0;
			settle_cycles_out <= `SETTLE_BASE;
		end
		else if (state_ff == sar_seq_pkg::ST_SET)
		begin
			conv_en_diff_out <= diff_ff; // RQ6 RQ7
			conv_ain_p_out <= ain_ff[7:4]; // RQ20
			conv_ain_n_out <= ain_ff[3:0]; // RQ20
			conv_vref_out <= vref_ff; // RQ6
			input_scale_select_out <= scale_ff; // RQ8
			conv_res_out <= res_ff; // RQ9
			conv_tsamp_out <= tsamp_ff; // RQ11
			settle_cycles_out <= settle_of(tsamp_ff); // RQ18
		end
	end

	conv_clk_div u_clk_div (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.power_down_in(power_down_ff),
		.div_in(clk_div_ff),
		.conv_clk_out(conv_clk_out)
	);

	// Result uses the resolution applied for this conversion
	result_capture u_result (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.latch_in(capture_end),
		.freeze_in(freeze_ff),
		.res_in(conv_res_out),
		.data_in(conv_data_in),
		.result_out(result)
	);

	assign reg_rdata_out = rdata_ff;
	assign converter_power_down_out = power_down_ff;
	assign conv_run_out = run_ff;
	assign result_valid_flag_out = result_valid_flag_ff;

	// Checking helpers: cycles spent in the current state
	logic [10:0] span_ff;
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in || nxt_state != state_ff)
			span_ff <= 11'h000;
		else
			span_ff <= span_ff + 11'h001;
	end

	chk_pd_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ1
		power_down_ff |=> state_ff == sar_seq_pkg::ST_IDLE)
		else $error("sequencer ran while powered down");
	chk_run_start: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ12
		run_ff |-> state_ff == sar_seq_pkg::ST_CAPTURE
			&& $past(state_ff) == sar_seq_pkg::ST_SET)
		else $error("run pulse not at capture start");
	chk_set_length: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ5
		(state_ff == sar_seq_pkg::ST_SET && nxt_state == sar_seq_pkg::ST_CAPTURE)
		|-> span_ff == 11'(set_last))
		else $error("set state length wrong");
	chk_cap_length: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ13
		(state_ff == sar_seq_pkg::ST_CAPTURE && nxt_state == sar_seq_pkg::ST_SET)
		|-> span_ff == 11'(cap_last))
		else $error("capture state length wrong");
	chk_valid_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ14
		result_valid_flag_ff |-> $past(state_ff) == sar_seq_pkg::ST_CAPTURE
			##1 !result_valid_flag_ff)
		else $error("valid flag not a single pulse");
	chk_idle_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ22
		(state_ff == sar_seq_pkg::ST_IDLE && $past(state_ff) == sar_seq_pkg::ST_IDLE)
		|-> !run_ff && !result_valid_flag_ff)
		else $error("activity while idle");
	chk_set_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ6
		state_ff == sar_seq_pkg::ST_SET |=> conv_res_out == $past(res_ff)
			&& conv_ain_p_out == $past(ain_ff[7:4]))
		else $error("controls not applied during set");
	chk_restart_set: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ21
		capture_end |=> state_ff == sar_seq_pkg::ST_SET)
		else $error("no return to set after capture");

	// Bus side: read data stands for one cycle only, so a stale byte is never taken twice
	chk_rdata_stands: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ15
		!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside its cycle");
	chk_result_hi: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ15
		$past(reset_n_in) && $past(reg_rd_in) && $past(reg_addr_in) == `ADDR_DAT_HI
		|-> reg_rdata_out == $past(result[15:8]))
		else $error("result high byte read wrong");
	chk_run_single: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ12
		run_ff |=> !run_ff)
		else $error("run pulse longer than one cycle");
	chk_disable_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ4
		!chan_en |=> state_ff == sar_seq_pkg::ST_IDLE)
		else $error("sequencer ran while disabled");

	// Controls stand between Set states so a capture sees one setting throughout
	chk_ctrl_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ6
		$past(reset_n_in) && $past(state_ff) != sar_seq_pkg::ST_SET
		|-> $stable(conv_res_out) && $stable(input_scale_select_out))
		else $error("controls changed outside set");
	// Codes run from zero to fifteen, so the count stays within three to forty-eight
	chk_settle_range: assert property (@(posedge clk_in) disable iff (!reset_n_in) // RQ18
		settle_cycles_out >= 6'h03 && settle_cycles_out <= 6'h30)
		else $error("settling count out of range");
endmodule // sar_adc_auto_sequencer

// ==== tb/conv_macro_model.sv ====
// Behavioural converter macro: answers each run pulse with a word.
// Assumes run is a one-cycle pulse in the sequencer's clock domain.
`timescale 1ns/100ps
module conv_macro_model #(
	parameter int CONV_CYCLES = 1 // Conversion time; must end before the last capture cycle
) (
	input wire logic clk_in, // Reference clock
	input wire logic reset_n_in, // Synchronous reset, active low
	input wire logic run_in, // Start of conversion
	input wire logic power_down_in, // Macro powered down
	input wire logic [13:0] word_in, // Word the next conversion yields
	output logic [13:0] data_out // Converter output word
);
	int busy_ff;
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			busy_ff <= 0;
			data_out <= 14'h0000;
		end
		else if (power_down_in)
			data_out <= ~data_out; // Unpowered output toggles every cycle, so the stale word shows every other cycle
		else if (run_in)
		begin
			busy_ff <= CONV_CYCLES;
			data_out <= ~data_out;
		end
		else if (busy_ff != 0)
		begin
			busy_ff <= busy_ff - 1;
			data_out <= (busy_ff == 1) ? word_in : ~data_out;
		end
	end
endmodule // conv_macro_model

// ==== tb/sar_adc_auto_sequencer_tb.sv ====
// Self-checking bench for the converter sequencer: registers, clock
// divider, Set/Capture timing, result format, freeze and disable.
// Assumes the macro model drives the raw converter word.
`timescale 1ns/100ps
module sar_adc_auto_sequencer_tb;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [13:0] word = 14'h0000;
	logic [7:0] reg_rdata_out;
	logic [13:0] conv_data;
	logic pd, cclk, run, diff, valid;
	logic [3:0] ain_p, ain_n, tsamp;
	logic [1:0] vref, scale, res;
	logic [5:0] settle;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int t0;
	logic [15:0] r;
	initial forever #50 clk_in = ~clk_in;
	always @(posedge clk_in) cyc <= cyc + 1;
	sar_adc_auto_sequencer u_sar_adc_auto_sequencer (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .conv_data_in(conv_data),
		.converter_power_down_out(pd), .conv_clk_out(cclk), .conv_run_out(run),
		.conv_en_diff_out(diff), .conv_ain_p_out(ain_p), .conv_ain_n_out(ain_n),
		.conv_vref_out(vref), .input_scale_select_out(scale), .conv_res_out(res),
		.conv_tsamp_out(tsamp), .settle_cycles_out(settle), .result_valid_flag_out(valid));
	conv_macro_model u_conv_macro_model (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.run_in(run), .power_down_in(pd), .word_in(word), .data_out(conv_data));
	task automatic tally_and_finish();
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// A cycle is left between strobes so no strobe is assigned twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	task automatic read_result(output logic [15:0] v);
		rd(8'hf8, v[15:8]);
		rd(8'hf7, v[7:0]);
	endtask
	task automatic wait_pulse(input bit sel_valid);
		for (int i = 0; i < 200; i++)
		begin
			@(posedge clk_in);
			#1;
			if ((sel_valid ? valid : run) === 1'b1)
				return;
		end
		n_errors++;
		$display("MISMATCH pulse wait expected 1 seen 0");
		tally_and_finish();
	endtask
	task automatic settle_runs();
		wait_pulse(0);
		wait_pulse(0);
		wait_pulse(1);
	endtask
	function automatic logic [15:0] sext(input logic [13:0] d, input int code);
		logic [15:0] v;
		int w;
		w = 8 + 2 * code;
		v = {2'h0, d};
		for (int i = 0; i < 16; i++)
			if (i >= w)
				v[i] = d[w - 1];
		return v;
	endfunction
	task automatic test_reset();
		logic [7:0] d;
		rd(8'hec, d);
		check("res reg", {8'h00, d}, 16'h0003);
		rd(8'hf4, d);
		check("div reg", {8'h00, d}, 16'h0003);
		rd(8'hfc, d);
		check("power reg", {8'h00, d}, 16'h0020);
		rd(8'h00, d);
		check("unmapped", {8'h00, d}, 16'h0000);
		check("res out", {14'h0000, res}, 16'h0003);
		check("settle out", {10'h000, settle}, 16'h0003);
	endtask
	task automatic test_power_down();
		int n;
		n = 0;
		wr(8'hf1, 8'h22);
		wr(8'hef, 8'h03);
		wr(8'hf2, 8'h24);
		repeat (20)
		begin
			@(posedge clk_in);
			#1 n += int'(run !== 1'b0) + int'(cclk !== 1'b0) + int'(pd !== 1'b1);
		end
		check("powered down activity", 16'(n), 16'h0000);
	endtask
	// Lets a new divide factor settle, then counts high cycles and rising edges over 30
	task automatic count_clk(output int hi, output int rises);
		logic p;
		hi = 0;
		rises = 0;
		repeat (10) @(posedge clk_in);
		#1 p = cclk;
		repeat (30)
		begin
			@(posedge clk_in);
			#1;
			hi += int'(cclk === 1'b1);
			rises += int'(cclk === 1'b1 && p === 1'b0);
			p = cclk;
		end
	endtask
	task automatic test_clk_div();
		int hi;
		int rises;
		wr(8'hf4, 8'h02);
		wr(8'hfc, 8'h00);
		count_clk(hi, rises);
		check("conv clk high count", 16'(hi), 16'd10);
		check("conv clk div3 edges", 16'(rises), 16'd10);
		wr(8'hf4, 8'h05);
		count_clk(hi, rises);
		check("conv clk div6 high", 16'(hi), 16'd15);
		check("conv clk div6 edges", 16'(rises), 16'd5);
	endtask
	task automatic test_sequence();
		wr(8'hea, 8'h02);
		wr(8'heb, 8'h12);
		wr(8'hec, 8'h41);
		wr(8'hee, 8'h05);
		wr(8'hfa, 8'h40);
		word <= 14'h0255;
		wait_pulse(0);
		wait_pulse(0);
		t0 = cyc;
		check("controls", {diff, ain_p, ain_n, vref, scale, res, 1'b0}, 16'h894a);
		check("tsamp", {6'h00, tsamp, settle}, 16'h0152);
		wait_pulse(1);
		check("run to valid", 16'(cyc - t0), 16'd3);
		@(posedge clk_in);
		#1 check("valid cleared", {15'h0000, valid}, 16'h0000);
		wait_pulse(0);
		check("period", 16'(cyc - t0), 16'd5);
		read_result(r);
		check("result", r, 16'hfe55);
	endtask
	task automatic test_res_loop();
		word <= 14'h2aaa;
		for (int c = 0; c < 4; c++)
		begin
			wr(8'hec, 8'h40 | 8'(c));
			settle_runs();
			read_result(r);
			check("res result", r, sext(word, c));
		end
	endtask
	task automatic test_freeze();
		wr(8'hf3, 8'h01);
		word <= 14'h1234;
		settle_runs();
		read_result(r);
		check("frozen", r, 16'heaaa);
		wr(8'hf3, 8'h00);
		settle_runs();
		read_result(r);
		check("unfrozen", r, 16'h1234);
	endtask
	task automatic test_disable();
		int n;
		n = 0;
		wr(8'hf2, 8'h20);
		word <= 14'h0fff;
		repeat (30)
		begin
			@(posedge clk_in);
			#1 n += int'(run !== 1'b0) + int'(valid !== 1'b0);
		end
		check("disabled pulses", 16'(n), 16'h0000);
		read_result(r);
		check("disabled result", r, 16'h1234);
	endtask
	initial
	begin
		repeat (20) @(posedge clk_in);
		reset_n_in <= 1'b1;
		test_reset();
		test_power_down();
		test_clk_div();
		test_sequence();
		test_res_loop();
		test_freeze();
		test_disable();
		tally_and_finish();
	end
endmodule // sar_adc_auto_sequencer_tb
